// File: pkg/i2c_host_map.svh
`ifndef I2C_HOST_MAP_SVH
`define I2C_HOST_MAP_SVH

// register offsets
`define REG_CMD 8'h00
`define REG_ADDR 8'h04
`define REG_STAT 8'h08

// command register fields
`define CMD_CODE_LSB 0
`define CMD_PARAM_LSB 8
`define CMD_SEND_BIT 16
`define CMD_WITH_PARAM_BIT 17
`define CMD_READ_BIT 18
`define CMD_RCNT_LSB 19

// address register fields
`define ADDR_SEL_LSB 0
`define RST_ADDR_SEL 2'h0

// status register fields
`define STAT_BUSY_BIT 0
`define STAT_ADDR_NACK_BIT 1
`define STAT_CMD_NACK_BIT 2
`define STAT_PARAM_NACK_BIT 3
`define STAT_DONE_BIT 4
`define STAT_LAST_LSB 8

// device address and codes
`define DEV_ADDR_HI 5'h06
`define CODE_TRIPLET 8'h78

// timing
`define CLK_KHZ 25000
`define LINK_RATE_KHZ 100
`define QUARTER_CYC (8'((`CLK_KHZ) / (`LINK_RATE_KHZ * 4)))

`endif

// File: pkg/i2c_host_pkg.sv
package i2c_host_pkg;

    typedef enum logic [1:0] {
        LS_IDLE,
        LS_START,
        LS_BIT,
        LS_STOP
    } link_state_t;

    typedef enum logic [2:0] {
        BS_ADDR_W,
        BS_CMD,
        BS_PARAM,
        BS_ADDR_R,
        BS_READ
    } byte_sel_t;

endpackage

// File: hw/i2c_host_command_port.sv
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "i2c_host_map.svh"

module i2c_host_command_port (
    // system
    input wire logic clk_sys,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // i2c link
    output logic scl_o,
    output logic scl_oe,
    output logic sda_o,
    output logic sda_oe,
    input wire logic sda_i
);

    i2c_host_pkg::link_state_t st;
    i2c_host_pkg::byte_sel_t bsel;
    logic [1:0] q;
    logic [7:0] qcnt;
    logic [3:0] idx;
    logic [7:0] tx_byte;
    logic [7:0] rx_byte;
    logic [2:0] rd_left;
    logic [7:0] cmd_code;
    logic [7:0] cmd_param;
    logic cmd_send;
    logic cmd_with_param;
    logic cmd_read;
    logic [2:0] cmd_rcnt;
    logic [1:0] addr_sel;
    logic go;
    logic done;
    logic addr_nack;
    logic cmd_nack;
    logic param_nack;
    logic [7:0] last_byte;
    logic sda_m1;
    logic sda_m2;
    logic sda_m3;
    logic sda_s;
    logic tick;
    logic byte_end;
    logic ack;
    logic busy;
    logic access;
    logic mapped;
    logic wr_cmd;
    logic wr_addr;
    logic wr_stat;
    logic ev_addr_nack;
    logic ev_cmd_nack;
    logic ev_param_nack;
    logic ev_read_byte;
    logic ev_done;
    logic [31:0] stat_word;
    logic [31:0] cmd_word;

    // apb decode
    assign access = psel & penable & pready;
    assign mapped = (paddr == `REG_CMD) | (paddr == `REG_ADDR) | (paddr == `REG_STAT);
    assign busy = (st != i2c_host_pkg::LS_IDLE) | go;
    assign wr_cmd = access & pwrite & (paddr == `REG_CMD) & ~busy;
    assign wr_addr = access & pwrite & (paddr == `REG_ADDR);
    assign wr_stat = access & pwrite & (paddr == `REG_STAT);

    always_comb begin
        stat_word = 32'h0;
        stat_word[`STAT_BUSY_BIT] = busy;
        stat_word[`STAT_ADDR_NACK_BIT] = addr_nack;
        stat_word[`STAT_CMD_NACK_BIT] = cmd_nack;
        stat_word[`STAT_PARAM_NACK_BIT] = param_nack;
        stat_word[`STAT_DONE_BIT] = done;
        stat_word[`STAT_LAST_LSB +: 8] = last_byte;
    end

    always_comb begin
        cmd_word = 32'h0;
        cmd_word[`CMD_CODE_LSB +: 8] = cmd_code;
        cmd_word[`CMD_PARAM_LSB +: 8] = cmd_param;
        cmd_word[`CMD_SEND_BIT] = cmd_send;
        cmd_word[`CMD_WITH_PARAM_BIT] = cmd_with_param;
        cmd_word[`CMD_READ_BIT] = cmd_read;
        cmd_word[`CMD_RCNT_LSB +: 3] = cmd_rcnt;
    end

    // one wait state on every access
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            prdata <= 32'h0;
            if (psel & penable & ~pready & ~pwrite) begin
                case (paddr)
                    `REG_CMD: prdata <= cmd_word;
                    `REG_ADDR: prdata <= {30'h0, addr_sel};
                    `REG_STAT: prdata <= stat_word;
                    default: prdata <= 32'h0;
                endcase
            end
        end
    end

    // command and address registers
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cmd_code <= 8'h0;
            cmd_param <= 8'h0;
            cmd_send <= 1'b0;
            cmd_with_param <= 1'b0;
            cmd_read <= 1'b0;
            cmd_rcnt <= 3'h0;
            addr_sel <= `RST_ADDR_SEL;
            go <= 1'b0;
        end else begin
            go <= wr_cmd & (pwdata[`CMD_SEND_BIT] | pwdata[`CMD_READ_BIT]);
            if (wr_cmd) begin
                cmd_code <= pwdata[`CMD_CODE_LSB +: 8];
                cmd_param <= pwdata[`CMD_PARAM_LSB +: 8];
                cmd_send <= pwdata[`CMD_SEND_BIT];
                cmd_with_param <= pwdata[`CMD_WITH_PARAM_BIT];
                cmd_read <= pwdata[`CMD_READ_BIT];
                cmd_rcnt <= pwdata[`CMD_RCNT_LSB +: 3];
            end
            if (wr_addr & ~busy) begin
                addr_sel <= pwdata[`ADDR_SEL_LSB +: 2];
            end
        end
    end

    // sda input synchroniser, change taken once stages agree
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sda_m1 <= 1'b1;
            sda_m2 <= 1'b1;
            sda_m3 <= 1'b1;
            sda_s <= 1'b1;
        end else begin
            sda_m1 <= sda_i;
            sda_m2 <= sda_m1;
            sda_m3 <= sda_m2;
            if (sda_m2 == sda_m3) begin
                sda_s <= sda_m3;
            end
        end
    end

    // quarter bit timer
    assign tick = (qcnt == `QUARTER_CYC - 8'h01);

    always_ff @(posedge clk_sys) begin
        if (sys_rst || st == i2c_host_pkg::LS_IDLE || tick) begin
            qcnt <= 8'h0;
        end else begin
            qcnt <= qcnt + 8'h01;
        end
    end

    // byte events
    assign byte_end = (st == i2c_host_pkg::LS_BIT) & tick & (q == 2'h3) & (idx == 4'h8);
    assign ack = ~sda_s;
    assign ev_addr_nack = byte_end & ~ack &
        ((bsel == i2c_host_pkg::BS_ADDR_W) | (bsel == i2c_host_pkg::BS_ADDR_R));
    assign ev_cmd_nack = byte_end & ~ack & (bsel == i2c_host_pkg::BS_CMD);
    assign ev_param_nack = byte_end & ~ack & (bsel == i2c_host_pkg::BS_PARAM);
    assign ev_read_byte = byte_end & (bsel == i2c_host_pkg::BS_READ);
    assign ev_done = (st == i2c_host_pkg::LS_STOP) & tick & (q == 2'h3);

    // link sequencer
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st <= i2c_host_pkg::LS_IDLE;
            bsel <= i2c_host_pkg::BS_ADDR_W;
            q <= 2'h0;
            idx <= 4'h0;
            tx_byte <= 8'h0;
            rx_byte <= 8'h0;
            rd_left <= 3'h0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            case (st)
                i2c_host_pkg::LS_IDLE: begin
                    if (go) begin
                        st <= i2c_host_pkg::LS_START;
                        q <= 2'h2;
                        bsel <= cmd_send ? i2c_host_pkg::BS_ADDR_W : i2c_host_pkg::BS_ADDR_R;
                        tx_byte <= {`DEV_ADDR_HI, addr_sel, ~cmd_send};
                        rd_left <= cmd_rcnt;
                    end
                end
                i2c_host_pkg::LS_START: begin
                    if (tick) begin
                        q <= q + 2'h1;
                        case (q)
                            2'h0: scl_oe <= 1'b1;
                            2'h1: sda_oe <= 1'b0;
                            2'h2: scl_oe <= 1'b0;
                            default: begin
                                sda_oe <= 1'b1;
                                st <= i2c_host_pkg::LS_BIT;
                                idx <= 4'h0;
                            end
                        endcase
                    end
                end
                i2c_host_pkg::LS_BIT: begin
                    if (tick) begin
                        q <= q + 2'h1;
                        case (q)
                            2'h0: scl_oe <= 1'b1;
                            2'h1: begin
                                if (bsel == i2c_host_pkg::BS_READ) begin
                                    sda_oe <= (idx == 4'h8) & (rd_left != 3'h0);
                                end else begin
                                    sda_oe <= (idx != 4'h8) & ~tx_byte[7];
                                end
                            end
                            2'h2: scl_oe <= 1'b0;
                            default: begin
                                if (idx != 4'h8) begin
                                    rx_byte <= {rx_byte[6:0], sda_s};
                                    tx_byte <= {tx_byte[6:0], 1'b0};
                                    idx <= idx + 4'h1;
                                end else begin
                                    idx <= 4'h0;
                                    st <= i2c_host_pkg::LS_STOP;
                                    case (bsel)
                                        i2c_host_pkg::BS_ADDR_W: begin
                                            if (ack) begin
                                                st <= i2c_host_pkg::LS_BIT;
                                                bsel <= i2c_host_pkg::BS_CMD;
                                                tx_byte <= cmd_code;
                                            end
                                        end
                                        i2c_host_pkg::BS_CMD: begin
                                            if (ack && cmd_with_param) begin
                                                st <= i2c_host_pkg::LS_BIT;
                                                bsel <= i2c_host_pkg::BS_PARAM;
                                                if (cmd_code == `CODE_TRIPLET) begin
                                                    tx_byte <= {cmd_param[7], 7'h0};
                                                end else begin
                                                    tx_byte <= cmd_param;
                                                end
                                            end else if (ack && cmd_read) begin
                                                st <= i2c_host_pkg::LS_START;
                                                bsel <= i2c_host_pkg::BS_ADDR_R;
                                                tx_byte <= {`DEV_ADDR_HI, addr_sel, 1'b1};
                                            end
                                        end
                                        i2c_host_pkg::BS_PARAM: begin
                                            if (ack && cmd_read) begin
                                                st <= i2c_host_pkg::LS_START;
                                                bsel <= i2c_host_pkg::BS_ADDR_R;
                                                tx_byte <= {`DEV_ADDR_HI, addr_sel, 1'b1};
                                            end
                                        end
                                        i2c_host_pkg::BS_ADDR_R: begin
                                            if (ack) begin
                                                st <= i2c_host_pkg::LS_BIT;
                                                bsel <= i2c_host_pkg::BS_READ;
                                            end
                                        end
                                        default: begin
                                            if (rd_left != 3'h0) begin
                                                st <= i2c_host_pkg::LS_BIT;
                                                rd_left <= rd_left - 3'h1;
                                            end
                                        end
                                    endcase
                                end
                            end
                        endcase
                    end
                end
                i2c_host_pkg::LS_STOP: begin
                    if (tick) begin
                        q <= q + 2'h1;
                        case (q)
                            2'h0: scl_oe <= 1'b1;
                            2'h1: sda_oe <= 1'b1;
                            2'h2: scl_oe <= 1'b0;
                            default: begin
                                sda_oe <= 1'b0;
                                st <= i2c_host_pkg::LS_IDLE;
                            end
                        endcase
                    end
                end
                default: st <= i2c_host_pkg::LS_IDLE;
            endcase
        end
    end

    // status flags, set wins over write-one clear
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            done <= 1'b0;
            addr_nack <= 1'b0;
            cmd_nack <= 1'b0;
            param_nack <= 1'b0;
            last_byte <= 8'h0;
        end else begin
            done <= ev_done | (done & ~(wr_stat & pwdata[`STAT_DONE_BIT]));
            addr_nack <= ev_addr_nack |
                (addr_nack & ~(wr_stat & pwdata[`STAT_ADDR_NACK_BIT]));
            cmd_nack <= ev_cmd_nack |
                (cmd_nack & ~(wr_stat & pwdata[`STAT_CMD_NACK_BIT]));
            param_nack <= ev_param_nack |
                (param_nack & ~(wr_stat & pwdata[`STAT_PARAM_NACK_BIT]));
            if (ev_read_byte) begin
                last_byte <= rx_byte;
            end
        end
    end

    // open-drain lines only ever pull low
    always_ff @(posedge clk_sys) begin
        scl_o <= 1'b0;
        sda_o <= 1'b0;
    end

    property p_start_only;
        @(posedge clk_sys) disable iff (sys_rst)
        ($rose(sda_oe) && !scl_oe)
        |-> (st == i2c_host_pkg::LS_BIT && $past(st) == i2c_host_pkg::LS_START);
    endproperty
    a_start_only: assert property (p_start_only)
        else $error("sda fell with scl high outside start");

    property p_stop_only;
        @(posedge clk_sys) disable iff (sys_rst)
        ($fell(sda_oe) && !scl_oe)
        |-> (st == i2c_host_pkg::LS_IDLE || st == i2c_host_pkg::LS_START);
    endproperty
    a_stop_only: assert property (p_stop_only)
        else $error("sda rose with scl high outside stop or start");

    property p_dir_bit;
        @(posedge clk_sys) disable iff (sys_rst)
        (st == i2c_host_pkg::LS_BIT && idx == 4'h7 && q == 2'h2 &&
         (bsel == i2c_host_pkg::BS_ADDR_W || bsel == i2c_host_pkg::BS_ADDR_R))
        |-> (sda_oe == (bsel == i2c_host_pkg::BS_ADDR_W));
    endproperty
    a_dir_bit: assert property (p_dir_bit) else $error("direction bit wrong");

    property p_cmd_msb;
        @(posedge clk_sys) disable iff (sys_rst)
        (st == i2c_host_pkg::LS_BIT && bsel == i2c_host_pkg::BS_CMD && idx == 4'h0 && q == 2'h2)
        |-> (sda_oe == ~cmd_code[7]);
    endproperty
    a_cmd_msb: assert property (p_cmd_msb) else $error("command byte not msb first");

    property p_triplet_param;
        @(posedge clk_sys) disable iff (sys_rst)
        (bsel == i2c_host_pkg::BS_PARAM && cmd_code == `CODE_TRIPLET && idx == 4'h0)
        |-> (tx_byte[6:0] == 7'h0);
    endproperty
    a_triplet_param: assert property (p_triplet_param)
        else $error("triplet low bits sent");

    property p_param_after_cmd;
        @(posedge clk_sys) disable iff (sys_rst)
        ($changed(bsel) && bsel == i2c_host_pkg::BS_PARAM)
        |-> ($past(bsel) == i2c_host_pkg::BS_CMD);
    endproperty
    a_param_after_cmd: assert property (p_param_after_cmd)
        else $error("parameter not after command");

    property p_read_readdress;
        @(posedge clk_sys) disable iff (sys_rst)
        ($changed(bsel) && bsel == i2c_host_pkg::BS_ADDR_R) |-> (st == i2c_host_pkg::LS_START);
    endproperty
    a_read_readdress: assert property (p_read_readdress)
        else $error("read without new start");

    property p_last_nack;
        @(posedge clk_sys) disable iff (sys_rst)
        (st == i2c_host_pkg::LS_BIT && bsel == i2c_host_pkg::BS_READ && idx == 4'h8 && q == 2'h2)
        |-> (sda_oe == (rd_left != 3'h0));
    endproperty
    a_last_nack: assert property (p_last_nack) else $error("read ack wrong");

    property p_busy_stop;
        @(posedge clk_sys) disable iff (sys_rst)
        ev_cmd_nack |=> (st == i2c_host_pkg::LS_STOP) ##1 cmd_nack;
    endproperty
    a_busy_stop: assert property (p_busy_stop)
        else $error("refused command not stopped");

    property p_nack_stop;
        @(posedge clk_sys) disable iff (sys_rst)
        (ev_addr_nack || ev_param_nack) |=> (st == i2c_host_pkg::LS_STOP)[*2];
    endproperty
    a_nack_stop: assert property (p_nack_stop) else $error("nack not followed by stop");

endmodule

// File: verification/i2c_dev_model.sv
`timescale 1ns/1ps
module i2c_dev_model #(
    parameter logic [7:0] PTR_STATUS = 8'hf0,
    parameter logic [7:0] PTR_DATA = 8'he1
) (
    // bus wires
    input wire logic scl,
    input wire logic sda,
    output logic sda_pull,
    // bench control
    input wire logic [1:0] strap,
    input wire logic line_busy_flag,
    input wire logic [7:0] rd_byte,
    // observed traffic
    output logic [7:0] last_code,
    output logic [7:0] last_param,
    output int rd_count
);
    // states: 0 idle, 1 addr, 2 code, 3 param, 4 read, 5 ignore
    int st = 0;
    int nxt = 0;
    int cnt = 0;
    logic ack;
    logic search_dir;
    logic [7:0] sh = 8'h00;
    logic [7:0] tx = 8'h00;
    logic [7:0] ptr = PTR_STATUS;

    initial begin
        sda_pull = 1'b0;
        last_code = 8'h00;
        last_param = 8'h00;
        rd_count = 0;
    end

    function automatic logic valid_code(logic [7:0] c);
        return c inside {8'hf0, 8'he1, 8'hd2,
            8'hb4, 8'h87, 8'ha5,
            8'h96, 8'h78};
    endfunction

    function automatic logic has_param(logic [7:0] c);
        return c inside {8'he1, 8'hd2, 8'h87, 8'ha5, 8'h78};
    endfunction

    always @(negedge sda) begin
        if (scl === 1'b1) begin
            st = 1;
            cnt = 0;
            sda_pull = 1'b0;
        end
    end

    always @(posedge sda) begin
        if (scl === 1'b1) begin
            st = 0;
            sda_pull = 1'b0;
        end
    end

    // scl only watched, never held low
    always @(posedge scl) begin
        if (cnt < 8 && st != 4) begin
            sh = {sh[6:0], sda};
        end
        st = (st == 4 && cnt == 8 && sda !== 1'b0) ? 5 : st;
        cnt = cnt + 1;
    end

    always @(negedge scl) begin
        if (cnt == 8 && st inside {1, 2, 3}) begin
            ack = 1'b0;
            nxt = 5;
            if (st == 1 && sh[7:1] == {5'b00110, strap}) begin
                ack = 1'b1;
                nxt = sh[0] ? 4 : 2;
            end
            if (st == 2 && valid_code(sh) && !line_busy_flag) begin
                ack = 1'b1;
                last_code = sh;
                nxt = has_param(sh) ? 3 : 5;
            end
            if (st == 3 &&
                (last_code != 8'he1 || sh inside {PTR_STATUS, PTR_DATA})) begin
                ack = 1'b1;
                last_param = sh;
                search_dir = sh[7];
                ptr = (last_code == 8'he1) ? sh : ptr;
            end
            sda_pull = ack;
            st = ack ? st : 5;
        end else if (cnt == 8 && st == 4) begin
            sda_pull = 1'b0;
        end else if (cnt == 9 && st inside {1, 2, 3, 4}) begin
            cnt = 0;
            st = (st == 4) ? 4 : nxt;
            sda_pull = 1'b0;
            if (st == 4) begin
                tx = (ptr == PTR_DATA) ? rd_byte :
                    {7'h00, line_busy_flag};
                rd_count = rd_count + 1;
                sda_pull = ~tx[7];
            end
        end else if (st == 4 && cnt >= 1 && cnt <= 7) begin
            sda_pull = ~tx[7 - cnt];
        end
    end
endmodule

// File: verification/testbench.sv
`timescale 1ns/1ps
`include "i2c_host_map.svh"
module testbench;
    localparam logic [7:0] PTR_STATUS = 8'hf0;
    localparam logic [7:0] PTR_DATA = 8'he1;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, sda_pull;
    logic [1:0] strap = 2'h0;
    logic busy_line = 1'b0;
    logic [7:0] rd_byte = 8'hc5;
    logic [7:0] last_code, last_param, prm;
    logic [7:0] codes [8] = '{8'hf0, 8'he1, 8'hd2, 8'hb4, 8'h87, 8'ha5, 8'h96, 8'h78};
    logic [31:0] rd, stat_seen;
    logic err, wp;
    int rd_count, n0;
    int errors = 0;
    int checked = 0;
    wire logic scl = !(scl_oe === 1'b1 && scl_o === 1'b0);
    wire logic sda = !((sda_oe === 1'b1 && sda_o === 1'b0) || sda_pull === 1'b1);

    initial begin
        forever #20 clk_sys = ~clk_sys;
    end

    i2c_host_command_port i_i2c_host_command_port (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe),
        .sda_i(sda)
    );

    i2c_dev_model #(.PTR_STATUS(PTR_STATUS), .PTR_DATA(PTR_DATA)) i_i2c_dev_model (
        .scl(scl), .sda(sda), .sda_pull(sda_pull), .strap(strap), .line_busy_flag(busy_line),
        .rd_byte(rd_byte), .last_code(last_code), .last_param(last_param), .rd_count(rd_count)
    );

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            errors++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [31:0] cmd_word(logic [7:0] c, logic [7:0] p, logic s, logic q,
                                             logic r, logic [2:0] k);
        return (32'(c) << `CMD_CODE_LSB) | (32'(p) << `CMD_PARAM_LSB)
            | (32'(s) << `CMD_SEND_BIT) | (32'(q) << `CMD_WITH_PARAM_BIT)
            | (32'(r) << `CMD_READ_BIT) | (32'(k) << `CMD_RCNT_LSB);
    endfunction

    task automatic job(input logic [31:0] cmd, input logic [4:0] flags);
        int n;
        apb(1'b1, `REG_CMD, cmd);
        n = 0;
        do begin
            apb(1'b0, `REG_STAT, 32'h0);
            n++;
        end while (rd[`STAT_BUSY_BIT] !== 1'b0 && n < 8000);
        if (rd[`STAT_BUSY_BIT] !== 1'b0) begin
            errors++;
            summarize();
        end
        stat_seen = rd;
        check("stat flags", {27'h0, rd[4:0]}, {27'h0, flags});
        check("bus released", {28'h0, scl_o, sda_o, scl_oe, sda_oe}, 32'h0);
        apb(1'b1, `REG_STAT, 32'h1e);
    endtask

    initial begin
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        apb(1'b0, `REG_CMD, 32'h0);
        check("cmd reset", rd, 32'h0);
        apb(1'b0, `REG_ADDR, 32'h0);
        check("addr reset", rd, 32'h0);
        apb(1'b0, `REG_STAT, 32'h0);
        check("stat reset", rd, 32'h0);
        check("bus idle", {30'h0, scl_oe, sda_oe}, 32'h0);
        apb(1'b0, 8'h0c, 32'h0);
        check("unmapped err", {31'h0, err}, 32'h1);
        check("unmapped data", rd, 32'h0);
        $display("reset and map test done");
        for (int i = 0; i < 8; i++) begin
            strap <= i[1:0];
            apb(1'b1, `REG_ADDR, 32'(i[1:0]));
            apb(1'b0, `REG_ADDR, 32'h0);
            check("addr readback", rd, 32'(i[1:0]));
            wp = codes[i] inside {8'he1, 8'hd2, 8'h87, 8'ha5, 8'h78};
            prm = (codes[i] == 8'he1) ? PTR_STATUS : 8'hff;
            job(cmd_word(codes[i], prm, 1'b1, wp, 1'b0, 3'h0), 5'h10);
            check("code seen", {24'h0, last_code}, {24'h0, codes[i]});
            if (wp) begin
                check("param seen", {24'h0, last_param},
                    (codes[i] == 8'h78) ? 32'h80 : 32'(prm));
            end
            $display("command %h test done", codes[i]);
        end
        strap <= 2'h1;
        apb(1'b1, `REG_ADDR, 32'h1);
        n0 = rd_count;
        job(cmd_word(8'he1, PTR_DATA, 1'b1, 1'b1, 1'b1, 3'h2), 5'h10);
        check("read byte", {24'h0, stat_seen[15:8]}, 32'hc5);
        check("read count", 32'(rd_count - n0), 32'h3);
        rd_byte <= 8'h3a;
        job(cmd_word(8'h00, 8'h00, 1'b0, 1'b0, 1'b1, 3'h0), 5'h10);
        check("read only byte", {24'h0, stat_seen[15:8]}, 32'h3a);
        $display("read test done");
        job(cmd_word(8'h11, 8'h00, 1'b1, 1'b0, 1'b0, 3'h0), 5'h14);
        busy_line <= 1'b1;
        job(cmd_word(8'ha5, 8'h55, 1'b1, 1'b1, 1'b0, 3'h0), 5'h14);
        check("busy refused", {24'h0, last_code}, 32'he1);
        busy_line <= 1'b0;
        job(cmd_word(8'he1, 8'h00, 1'b1, 1'b1, 1'b0, 3'h0), 5'h18);
        apb(1'b1, `REG_ADDR, 32'h2);
        job(cmd_word(8'hf0, 8'h00, 1'b1, 1'b0, 1'b0, 3'h0), 5'h12);
        $display("refusal test done");
        summarize();
    end
endmodule
